/* File: logic/ioe_top.sv */
// Notes on behaviour
// [RULE_01] alert pulls low while any input pin differs from its captured value
// [RULE_02] any edge on an input pin raises the alert within 4 us
// [RULE_03] alert clears when pins return or the input register is read
// [RULE_04] on a read, clearing happens at the ack bit after scl rises
// [RULE_05] a change inside the read ack pulse may be lost or very short
// [RULE_06] after every clearing, further input changes raise the alert again
// [RULE_07] traffic for other slave addresses neither sets nor clears the alert
// [RULE_08] an output-configured pin never raises the alert
// [RULE_09] turning an output into an input may raise a spurious alert
// [RULE_10] the alert pin only pulls low or floats, never drives high
// [RULE_11] holding the reset pin low forces registers and serial engine to defaults
// [RULE_12] reset pin and power-on reset give the same initial state
// [RULE_13] after reset pin rises, pins and registers may change again
// [RULE_14] after power-up all eight pins are inputs until configured
// [RULE_15] four 8-bit registers: configuration, input, output, polarity
// [RULE_16] a set polarity bit inverts that pin in the input register
// [RULE_17] all four registers are readable by the serial master
// [RULE_18] an input pin has both drivers off, high impedance
// [RULE_19] an output pin drives high or low from the output register
// [RULE_20] two address select pins set the low address bits, four devices
// [RULE_21] command byte codes 0 to 3 pick the register; reads keep it
// [RULE_22] slave address is 0x70 to 0x73; last address bit high means read
// [RULE_23] configuration bit 1 makes an input, 0 an output
// [RULE_24] reading the output register returns the flip-flops, not the pins
// [RULE_25] port pins are synchronised before alert comparison
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module ioe_top
    import ioe_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_sel_bit0,
    input wire logic addr_sel_bit1,
    input wire logic dev_reset_n_in,
    input wire logic [IOE_WIDTH-1:0] port_pins_in,
    output logic [IOE_WIDTH-1:0] port_pins_out,
    output logic [IOE_WIDTH-1:0] port_pins_oe,
    output logic alert_n_out,
    output logic alert_oe
);
    logic [1:0] bus_s;
    logic [2:0] strap_s;
    logic [IOE_WIDTH-1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic soft_rst;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    ioe_state_t state_q;
    ioe_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic rw_q;
    logic rw_d;
    logic drv_q;
    logic drv_d;
    logic mack_q;
    logic mack_d;
    logic [1:0] ptr_q;
    logic [1:0] ptr_d;
    logic [7:0] out_q;
    logic [7:0] pol_q;
    logic [7:0] cfg_q;
    logic ctrl_en_q;
    logic [31:0] prdata_q;
    logic [IOE_WIDTH-1:0] snap;
    logic alert;
    logic addr_hit;
    logic byte_done;
    logic wr_strobe;
    logic capture;
    logic [7:0] in_view;
    logic [7:0] rd_byte;
    logic apb_setup;
    logic apb_acc;
    logic apb_wr;
    logic sel_input;
    logic sel_output;
    logic sel_pol;
    logic sel_cfg;
    logic sel_ctrl;
    logic sel_status;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    // serial lines, straps and port pins all come from outside the clock
    ioe_sync #(.W(2), .RST(2'h3)) u_sync_bus
    (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .d({scl_in, sda_in}),
        .q(bus_s)
    );

    ioe_sync #(.W(3), .RST(3'h1)) u_sync_strap
    (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .d({addr_sel_bit1, addr_sel_bit0, dev_reset_n_in}),
        .q(strap_s)
    );

    ioe_sync #(.W(IOE_WIDTH), .RST('0)) u_sync_pins
    (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .d(port_pins_in),
        .q(pins_s) // [RULE_25]
    );

    ioe_alert #(.W(IOE_WIDTH)) u_alert
    (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .clr(soft_rst),
        .pins(pins_s),
        .cfg(cfg_q),
        .capture(capture),
        .snap(snap),
        .alert(alert)
    );

    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];
    assign soft_rst = ~strap_s[0]; // [RULE_11] [RULE_13]

    // serial line events
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
    assign addr_hit = ctrl_en_q & (sh_q[7:1] == {IOE_ADDR_HI, strap_s[2:1]}); // [RULE_20] [RULE_22]
    assign byte_done = scl_fall & (cnt_q == 4'h8);
    assign wr_strobe = byte_done & (state_q == IOE_ST_WR);

    // capture at the ack rising edge only when this slave is reading input
    assign capture = scl_rise & (ptr_q == IOE_CMD_INPUT) & ~soft_rst
        & (((state_q == IOE_ST_ACK_ADDR) & rw_q)
        | ((state_q == IOE_ST_ACK_RD) & ~sda_s)); // [RULE_04] [RULE_07]

    assign in_view = snap ^ pol_q; // [RULE_16]
    assign rd_byte = (ptr_q == IOE_CMD_INPUT) ? in_view :
        (ptr_q == IOE_CMD_OUTPUT) ? out_q :
        (ptr_q == IOE_CMD_POLARITY) ? pol_q : cfg_q; // [RULE_17] [RULE_24]

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        rw_d = rw_q;
        drv_d = drv_q;
        mack_d = mack_q;
        ptr_d = ptr_q;
        if (start_cond)
        begin
            state_d = IOE_ST_ADDR;
            cnt_d = 4'h0;
            drv_d = 1'b0;
        end
        else if (stop_cond)
        begin
            state_d = IOE_ST_IDLE;
            drv_d = 1'b0;
        end
        else
        begin
            case (state_q)
                IOE_ST_ADDR, IOE_ST_CMD, IOE_ST_WR:
                begin
                    if (scl_rise)
                    begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        cnt_d = 4'h0;
                        if (state_q == IOE_ST_CMD)
                        begin
                            state_d = IOE_ST_ACK_CMD;
                            ptr_d = sh_q[1:0]; // [RULE_21]
                            drv_d = 1'b1;
                        end
                        else if (state_q == IOE_ST_WR)
                        begin
                            state_d = IOE_ST_ACK_WR;
                            drv_d = 1'b1;
                        end
                        else if (addr_hit)
                        begin
                            state_d = IOE_ST_ACK_ADDR;
                            rw_d = sh_q[0]; // [RULE_22]
                            drv_d = 1'b1;
                        end
                        else
                        begin
                            // foreign address: stay silent until the next start
                            state_d = IOE_ST_IDLE; // [RULE_07]
                        end
                    end
                end
                IOE_ST_ACK_ADDR:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = 4'h0;
                        if (rw_q)
                        begin
                            state_d = IOE_ST_RD;
                            tx_d = rd_byte;
                            drv_d = ~rd_byte[7];
                        end
                        else
                        begin
                            state_d = IOE_ST_CMD;
                            drv_d = 1'b0;
                        end
                    end
                end
                IOE_ST_ACK_CMD, IOE_ST_ACK_WR:
                begin
                    if (scl_fall)
                    begin
                        state_d = IOE_ST_WR;
                        cnt_d = 4'h0;
                        drv_d = 1'b0;
                    end
                end
                IOE_ST_RD:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_q == 4'h7)
                        begin
                            state_d = IOE_ST_ACK_RD;
                            drv_d = 1'b0;
                        end
                        else
                        begin
                            drv_d = ~tx_q[6];
                            tx_d = {tx_q[6:0], 1'b0};
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                IOE_ST_ACK_RD:
                begin
                    if (scl_rise)
                    begin
                        mack_d = ~sda_s;
                    end
                    else if (scl_fall)
                    begin
                        cnt_d = 4'h0;
                        if (mack_q)
                        begin
                            // same register again until a new command byte
                            state_d = IOE_ST_RD; // [RULE_21]
                            tx_d = rd_byte;
                            drv_d = ~rd_byte[7];
                        end
                        else
                        begin
                            state_d = IOE_ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_d = IOE_ST_IDLE;
                end
            endcase
        end
    end

    // serial engine; the reset pin holds it idle like a power-on reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state_q <= IOE_ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            drv_q <= 1'b0;
            mack_q <= 1'b0;
        end
        else if (ce)
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            state_q <= soft_rst ? IOE_ST_IDLE : state_d; // [RULE_11] [RULE_12]
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            rw_q <= rw_d;
            drv_q <= ~soft_rst & drv_d;
            mack_q <= mack_d;
        end
    end

    // device registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr_q <= IOE_PTR_RST;
            out_q <= IOE_OUT_RST;
            pol_q <= IOE_POL_RST;
            cfg_q <= IOE_CFG_RST; // [RULE_14]
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                ptr_q <= IOE_PTR_RST; // [RULE_11] [RULE_12]
                out_q <= IOE_OUT_RST;
                pol_q <= IOE_POL_RST;
                cfg_q <= IOE_CFG_RST;
            end
            else
            begin
                ptr_q <= ptr_d;
                // input register ignores writes
                if (wr_strobe && ptr_q == IOE_CMD_OUTPUT)
                begin
                    out_q <= sh_q; // [RULE_15]
                end
                if (wr_strobe && ptr_q == IOE_CMD_POLARITY)
                begin
                    pol_q <= sh_q;
                end
                if (wr_strobe && ptr_q == IOE_CMD_CONFIG)
                begin
                    cfg_q <= sh_q; // [RULE_23]
                end
            end
        end
    end

    // apb side: mirrors of the device plus enable and status
    assign apb_setup = psel & ~penable;
    assign apb_acc = psel & penable;
    assign apb_wr = apb_acc & pwrite & pready;
    assign sel_input = paddr == IOE_OFF_INPUT;
    assign sel_output = paddr == IOE_OFF_OUTPUT;
    assign sel_pol = paddr == IOE_OFF_POLARITY;
    assign sel_cfg = paddr == IOE_OFF_CONFIG;
    assign sel_ctrl = paddr == IOE_OFF_CTRL;
    assign sel_status = paddr == IOE_OFF_STATUS;
    assign addr_ok = sel_input | sel_output | sel_pol | sel_cfg | sel_ctrl | sel_status;
    assign status_word = ({24'h0, pins_s} << IOE_STAT_PINS_LSB)
        | ({31'h0, state_q != IOE_ST_IDLE} << IOE_STAT_BUSY_BIT)
        | ({31'h0, alert} << IOE_STAT_ALERT_BIT);
    assign rd_mux = sel_input ? {24'h0, in_view} :
        sel_output ? {24'h0, out_q} :
        sel_pol ? {24'h0, pol_q} :
        sel_cfg ? {24'h0, cfg_q} :
        sel_ctrl ? ({31'h0, ctrl_en_q} << IOE_CTRL_EN_BIT) :
        sel_status ? status_word : 32'h0;
    assign pready = 1'b1;
    assign pslverr = apb_acc & ~addr_ok;
    assign prdata = prdata_q;

    // read data registered in setup so it stands for the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0;
            ctrl_en_q <= IOE_CTRL_EN_RST;
        end
        else if (ce)
        begin
            if (apb_setup)
            begin
                prdata_q <= rd_mux;
            end
            if (apb_wr && sel_ctrl)
            begin
                ctrl_en_q <= pwdata[IOE_CTRL_EN_BIT];
            end
        end
    end

    // pins: open drain for sda and alert, push-pull for the port
    assign sda_out = 1'b0;
    assign sda_oe = drv_q;
    assign port_pins_out = out_q; // [RULE_19]
    assign port_pins_oe = ~cfg_q; // [RULE_18] [RULE_23]
    assign alert_n_out = 1'b0; // [RULE_10]
    assign alert_oe = alert; // [RULE_01]
endmodule

/* File: logic/ioe_pkg.sv */
package ioe_pkg;
    // port width and the fixed part of the serial slave address
    localparam int IOE_WIDTH = 8;
    localparam logic [4:0] IOE_ADDR_HI = 5'h1c;

    // command byte codes, low two bits of the command byte
    localparam logic [1:0] IOE_CMD_INPUT = 2'h0;
    localparam logic [1:0] IOE_CMD_OUTPUT = 2'h1;
    localparam logic [1:0] IOE_CMD_POLARITY = 2'h2;
    localparam logic [1:0] IOE_CMD_CONFIG = 2'h3;

    // reset values
    localparam logic [7:0] IOE_OUT_RST = 8'hff;
    localparam logic [7:0] IOE_POL_RST = 8'h00;
    localparam logic [7:0] IOE_CFG_RST = 8'hff;
    localparam logic [1:0] IOE_PTR_RST = 2'h0;
    localparam logic IOE_CTRL_EN_RST = 1'b1;

    // apb byte offsets
    localparam logic [7:0] IOE_OFF_INPUT = 8'h00;
    localparam logic [7:0] IOE_OFF_OUTPUT = 8'h04;
    localparam logic [7:0] IOE_OFF_POLARITY = 8'h08;
    localparam logic [7:0] IOE_OFF_CONFIG = 8'h0c;
    localparam logic [7:0] IOE_OFF_CTRL = 8'h10;
    localparam logic [7:0] IOE_OFF_STATUS = 8'h14;

    // field positions
    localparam int IOE_CTRL_EN_BIT = 0;
    localparam int IOE_STAT_ALERT_BIT = 0;
    localparam int IOE_STAT_BUSY_BIT = 1;
    localparam int IOE_STAT_PINS_LSB = 8;

    // timing
    localparam int IOE_CLK_NS = 8;
    localparam int IOE_ALERT_VALID_NS = 4000;
    localparam int IOE_ALERT_VALID_CYC = IOE_ALERT_VALID_NS / IOE_CLK_NS;
    localparam int IOE_ALERT_LAT_CYC = 6;

    typedef enum logic [3:0] {
        IOE_ST_IDLE,
        IOE_ST_ADDR,
        IOE_ST_ACK_ADDR,
        IOE_ST_CMD,
        IOE_ST_ACK_CMD,
        IOE_ST_WR,
        IOE_ST_ACK_WR,
        IOE_ST_RD,
        IOE_ST_ACK_RD
    } ioe_state_t;
endpackage

/* File: logic/ioe_sync.sv */
`timescale 1ns/1ns
module ioe_sync
    import ioe_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    if (W < 1)
    begin : g_chk
        $error("ioe_sync width must be at least one");
    end

    // value moves only once the last two stages agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            q <= RST;
        end
        else if (ce)
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q <= (s2_q == s3_q) ? s3_q : q;
        end
    end
endmodule

/* File: logic/ioe_alert.sv */
`timescale 1ns/1ns
module ioe_alert
    import ioe_pkg::*;
#(
    parameter int W = IOE_WIDTH
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic [W-1:0] pins,
    input wire logic [W-1:0] cfg,
    input wire logic capture,
    output logic [W-1:0] snap,
    output logic alert
);
    logic primed_q;
    logic [W-1:0] diff;
    logic [2:0] settle_q;

    if (W < 1 || IOE_ALERT_LAT_CYC > IOE_ALERT_VALID_CYC)
    begin : g_chk
        $error("ioe_alert cannot meet the alert valid time");
    end

    // only input-configured pins may differ
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign diff[i] = cfg[i] & (pins[i] ^ snap[i]); // [RULE_08] [RULE_09]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            primed_q <= 1'b0;
            snap <= '0;
            settle_q <= 3'h0;
            alert <= 1'b0;
        end
        else if (ce)
        begin
            if (clr)
            begin
                primed_q <= 1'b0;
            end
            else if (!primed_q || capture)
            begin
                // pins need a few cycles through the synchroniser after reset
                settle_q <= settle_q + {2'h0, ~&settle_q};
                primed_q <= primed_q | (&settle_q);
                snap <= pins; // [RULE_03] [RULE_04]
            end
            // a change landing on the capture cycle is absorbed, by design
            alert <= primed_q & ~capture & ~clr & (|diff); // [RULE_01] [RULE_02] [RULE_05] [RULE_06]
        end
    end
endmodule

/* File: bench/ioe_monitor.sv */
`timescale 1ns/1ns
module ioe_monitor
    import ioe_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic scl_in,
    input wire logic dev_reset_n_in,
    input wire logic [IOE_WIDTH-1:0] port_pins_in,
    input wire logic [IOE_WIDTH-1:0] port_pins_out,
    input wire logic [IOE_WIDTH-1:0] port_pins_oe,
    input wire logic alert_n_out,
    input wire logic alert_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_acc = psel && penable && !pwrite;

    chk_alert_pull_only: assert property (alert_n_out == 1'b0)
        else $error("alert pin driven high");
    // quiet bus and pins around the change, else a capture may absorb it
    chk_alert_set_time: assert property ($changed(port_pins_in & ~port_pins_oe) && !alert_oe
        && dev_reset_n_in ##1 ($stable(port_pins_in) && $stable(scl_in))[*8] |-> ##[0:492] alert_oe)
        else $error("input change not flagged in time");
    chk_output_quiet: assert property (($stable(port_pins_in | port_pins_oe)
        && $stable(port_pins_oe) && !alert_oe)[*8] |=> !alert_oe)
        else $error("alert without input change");
    chk_reset_pin: assert property ((!dev_reset_n_in)[*6] |-> !alert_oe
        && port_pins_oe == 8'h00 && port_pins_out == 8'hff)
        else $error("reset pin did not restore defaults");
    chk_power_on: assert property ($rose(presetn) |-> !alert_oe
        && port_pins_oe == 8'h00 && port_pins_out == 8'hff)
        else $error("power on state wrong");
    chk_cfg_read: assert property (rd_acc && paddr == IOE_OFF_CONFIG
        |-> prdata[7:0] == ~port_pins_oe)
        else $error("config read disagrees with drivers");
    chk_out_read: assert property (rd_acc && paddr == IOE_OFF_OUTPUT
        |-> prdata[7:0] == port_pins_out)
        else $error("output read disagrees with flops");
    chk_unmapped_err: assert property (psel && penable && paddr > IOE_OFF_STATUS
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    cov_alert: cover property ($rose(alert_oe));
    cov_reset_pin: cover property ((!dev_reset_n_in)[*6]);
    cov_refused: cover property (pslverr);
endmodule

bind ioe_top ioe_monitor u_mon (.*);

/* File: bench/ioe_i2c_master.sv */
`timescale 1ns/1ns
module ioe_i2c_master
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // scl stands high between frames; each phase is five pclk
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic start();
        tick(2);
        sda_low <= 1'b1;
        tick(5);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_low <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(5);
        sda_low <= 1'b0;
        tick(5);
    endtask
    // eight bits msb first then ack; sampled late in high phase for slow slaves
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
        logic [8:0] v;
        logic [8:0] s;
        v = {tx, ack_in};
        for (int i = 8; i >= 0; i--)
        begin
            tick(2);
            sda_low <= !v[i];
            tick(3);
            scl <= 1'b1;
            tick(4);
            s[i] = sda;
            tick(1);
            scl <= 1'b0;
        end
        rx = s[8:1];
        ack = s[0];
    endtask
endmodule

/* File: bench/i2c_gpio_expander_8bit_bench.sv */
`timescale 1ns/1ns
module i2c_gpio_expander_8bit_bench;
    import ioe_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sda_out, sda_oe;
    logic alert_n_out, alert_oe, dev_n, scl, m_low, ak;
    logic [1:0] asel;
    logic [7:0] paddr, ext, pins, p_out, p_oe, d;
    logic [31:0] pwdata, prdata;
    int fails, checks_done;
    localparam logic [6:0] SLV = {IOE_ADDR_HI, 2'b10};
    // sda has a pull-up: released by both means high
    wire sda = !(m_low || (sda_oe && !sda_out));
    assign pins = (p_oe & p_out) | (~p_oe & ext);

    ioe_top u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_sel_bit0(asel[0]), .addr_sel_bit1(asel[1]), .dev_reset_n_in(dev_n),
        .port_pins_in(pins), .port_pins_out(p_out), .port_pins_oe(p_oe),
        .alert_n_out(alert_n_out), .alert_oe(alert_oe));
    ioe_i2c_master u_mst (.clk(pclk), .sda(sda), .scl(scl), .sda_low(m_low));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic er;
        apb(a, 1'b0, 32'h0, r, er);
        chk({er, r}, {1'b0, e});
    endtask
    task automatic i2c_wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] dv,
                          input bit wd, output logic ok);
        logic [7:0] rx;
        logic k1, k2, k3;
        u_mst.start();
        u_mst.xfer({a, 1'b0}, 1'b1, rx, k1);
        u_mst.xfer(c, 1'b1, rx, k2);
        k3 = 1'b0;
        if (wd)
            u_mst.xfer(dv, 1'b1, rx, k3);
        u_mst.stop();
        ok = !(k1 | k2 | k3);
    endtask
    // single byte read, ended by nack
    task automatic i2c_rd(input logic [6:0] a, output logic [7:0] dv, output logic ok);
        logic k1, k2;
        u_mst.start();
        u_mst.xfer({a, 1'b1}, 1'b1, dv, k1);
        u_mst.xfer(8'hff, 1'b1, dv, k2);
        u_mst.stop();
        ok = !k1;
    endtask
    task automatic wait_alert(input logic v);
        int n;
        n = 0;
        while (alert_oe !== v && n < 500)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic t_defaults();
        logic [31:0] r;
        logic er;
        rdchk(IOE_OFF_INPUT, {24'h0, ext});
        rdchk(IOE_OFF_OUTPUT, 32'hff);
        rdchk(IOE_OFF_POLARITY, 32'h0);
        rdchk(IOE_OFF_CONFIG, 32'hff);
        chk(p_oe, 8'h00);
        apb(8'h20, 1'b0, 32'h0, r, er);
        chk({er, r}, {1'b1, 32'h0});
        apb(IOE_OFF_CTRL, 1'b1, 32'h0, r, er);
        rdchk(IOE_OFF_CTRL, 32'h0);
        i2c_wr(SLV, 8'h03, 8'h0f, 1, ak);
        chk(ak, 1'b0);
        apb(IOE_OFF_CTRL, 1'b1, 32'h1, r, er);
    endtask
    task automatic t_regs();
        logic [7:0] ex [4];
        i2c_wr(SLV, 8'h03, 8'h0f, 1, ak);
        chk(ak, 1'b1);
        chk(p_oe, 8'hf0);
        i2c_wr(SLV, 8'h01, 8'ha5, 1, ak);
        chk(p_out, 8'ha5);
        i2c_wr(SLV, 8'h02, 8'h03, 1, ak);
        i2c_wr(SLV, 8'h00, 8'h55, 1, ak);
        wait_alert(1'b1);
        chk(alert_oe, 1'b0);
        ex = '{pins ^ 8'h03, 8'ha5, 8'h03, 8'h0f};
        for (int c = 0; c < 4; c++)
        begin
            i2c_wr(SLV, 8'(c), 8'h0, 0, ak);
            i2c_rd(SLV, d, ak);
            chk(d, ex[c]);
        end
        i2c_rd(SLV, d, ak);
        chk(d, 8'h0f);
        rdchk(IOE_OFF_OUTPUT, 32'ha5);
        rdchk(IOE_OFF_POLARITY, 32'h03);
        rdchk(IOE_OFF_CONFIG, 32'h0f);
        asel <= 2'b01;
        repeat (8) @(posedge pclk);
        i2c_rd({IOE_ADDR_HI, 2'b01}, d, ak);
        chk(ak, 1'b1);
        asel <= 2'b10;
        repeat (8) @(posedge pclk);
    endtask
    task automatic t_alert();
        i2c_wr(SLV, 8'h00, 8'h0, 0, ak);
        @(posedge pclk);
        ext <= ext ^ 8'h01;
        wait_alert(1'b1);
        chk(alert_oe, 1'b1);
        ext <= ext ^ 8'h01;
        wait_alert(1'b0);
        chk(alert_oe, 1'b0);
        ext <= ext ^ 8'h02;
        wait_alert(1'b1);
        i2c_wr(7'h70, 8'h00, 8'h0, 0, ak);
        i2c_rd(7'h70, d, ak);
        chk({ak, alert_oe}, 2'b01);
        i2c_rd(SLV, d, ak);
        chk(d, pins ^ 8'h03);
        wait_alert(1'b0);
        chk(alert_oe, 1'b0);
        ext <= ext ^ 8'h04;
        wait_alert(1'b1);
        chk(alert_oe, 1'b1);
        rdchk(IOE_OFF_STATUS, {16'h0, pins, 8'h01});
        i2c_rd(SLV, d, ak);
    endtask
    task automatic t_devreset();
        logic [31:0] r;
        logic er;
        @(posedge pclk);
        dev_n <= 1'b0;
        repeat (8) @(posedge pclk);
        chk({p_oe, p_out, 7'h0, alert_oe}, {8'h00, 8'hff, 8'h00});
        dev_n <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk(IOE_OFF_POLARITY, 32'h0);
        rdchk(IOE_OFF_CONFIG, 32'hff);
        i2c_wr(SLV, 8'h01, 8'h5a, 1, ak);
        chk(ak, 1'b1);
        rdchk(IOE_OFF_OUTPUT, 32'h5a);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        dev_n = 1'b1;
        asel = 2'b10;
        ext = 8'h3c;
        fails = 0;
        checks_done = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        t_defaults();
        t_regs();
        t_alert();
        t_devreset();
        end_sim();
    end
    // whole run is near 5.5k cycles, well inside the 100k-cycle limit below
    initial
    begin
        #800000;
        fails++;
        end_sim();
    end
endmodule
